// file: include/burst_if.sv
`timescale 1ns/1ns
`default_nettype none

interface burst_if;
    logic load;
    logic len8;
    logic [9:0] start_col;
    logic [9:0] col;
    logic beat_valid;

    modport gen (input load, input len8, input start_col, output col, output beat_valid);
    modport user (output load, output len8, output start_col, input col, input beat_valid);
endinterface : burst_if

`default_nettype wire

// file: include/sdram_init_map.svh
`ifndef SDRAM_INIT_MAP_SVH
`define SDRAM_INIT_MAP_SVH

// Clock rate in MHz
`define CLK_MHZ 10
// Mode update delay, in controller clocks
`define MODE_UPDATE_CYCLES 5'h0c
// Mode-to-mode gap, in controller clocks
`define MODE_TO_MODE_CYCLES 5'h04
// DLL lock time, in clocks
`define DLL_LOCK_CYCLES 10'h200

// Register select codes on the bank address
`define SEL_BASE 3'h0
`define SEL_AUX_A 3'h1
`define SEL_AUX_B 3'h2
`define SEL_AUX_C 3'h3

// Field positions
`define BASE_DLL_RESET_BIT 8
`define BASE_BL_LSB 0
`define AUX_A_LEVEL_BIT 7
`define AUX_A_QOFF_BIT 12
`define AUX_A_RTT_B0 2
`define AUX_A_RTT_B1 6
`define AUX_A_RTT_B2 9
`define BURST_SEL_BIT 12

// Burst length field encodings
`define BL_FIXED8 2'h0
`define BL_OTF 2'h1
`define BL_CHOP4 2'h2

// Reset values
`define MODE_REG_RESET 16'h0000
`define COL_RESET 10'h000

`endif

// file: include/sdram_init_pkg.sv
package sdram_init_pkg;

    typedef enum logic [2:0] {
        CMD_DESELECT,
        CMD_NOP,
        CMD_MODE_SET,
        CMD_READ,
        CMD_WRITE,
        CMD_OTHER
    } cmd_type;

    typedef enum logic [0:0] {
        MODE_STABLE,
        MODE_UPDATING
    } mode_state_type;

    typedef struct packed {
        logic [3:0][15:0] mode_reg;
        logic [3:0][15:0] active_reg;
        mode_state_type mstate;
        logic [4:0] upd_cnt;
        logic [4:0] mrd_cnt;
        logic [9:0] dll_cnt;
        logic dll_locked;
        logic cke_seen;
        logic dq_undef;
        logic [7:0] dq_out;
        logic [7:0] dq_oe_n;
        logic term_on;
        logic dqs_prev;
        logic ck_sample;
        logic [9:0] burst_col;
        logic burst_valid;
        logic burst_len8;
        logic cmd_error;
    } top_state_type;

    typedef struct packed {
        logic active;
        logic len8;
        logic [9:0] base;
        logic [2:0] cnt;
    } burst_state_type;

endpackage : sdram_init_pkg

// file: src/burst_addr_gen.sv
`timescale 1ns/1ns
`default_nettype none

module burst_addr_gen (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Burst request and beat addresses
    burst_if.gen bus
);
    sdram_init_pkg::burst_state_type st_r;
    sdram_init_pkg::burst_state_type st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (bus.load)
        begin
            st_nxt.active = 1'b1;
            st_nxt.len8 = bus.len8;
            st_nxt.base = bus.start_col;
            st_nxt.cnt = 3'h0;
        end
        else if (st_r.active)
        begin
            st_nxt.cnt = st_r.cnt + 3'h1;
            if ((st_r.len8 && st_r.cnt == 3'h7) || (!st_r.len8 && st_r.cnt == 3'h3))
            begin
                st_nxt.active = 1'b0;
            end
        end
    end

    // Wrap inside the block, low bits give the start
    always_comb
    begin
        if (st_r.len8)
        begin
            bus.col = {st_r.base[9:3], 3'(st_r.base[2:0] + st_r.cnt)};
        end
        else
        begin
            bus.col = {st_r.base[9:2], 2'(st_r.base[1:0] + st_r.cnt[1:0])};
        end
        bus.beat_valid = st_r.active;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
endmodule : burst_addr_gen

`default_nettype wire

// file: src/sdram_init_mode_register_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdram_init_map.svh"

// Summary of operation
// - Data lines undefined from leveling exit until mode update delay after mode set.
// - While leveling, bit zero returns sampled clock, other data bits driven low.
// - Termination stays off during clear and until clock enable first seen high.
// - Mode registers hold until rewritten or cleared; DLL reset bit self-clears.
// - Only idle commands, or mode sets after the mode-to-mode gap, before mode update delay; new settings apply after it.
// - Burst field picks chop-four, eight, or on-the-fly by address bit twelve.
// - Burst wraps in a four or eight column block; low bits give start.
// - Aux register A bit seven enables leveling, bit twelve disables outputs.
module sdram_init_mode_register_control (
    // Clock and clear pin
    input wire logic clk_sys,
    input wire logic rst_n,
    // Command pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [15:0] addr,
    input wire logic termination_enable,
    // Leveling strobe and clock level
    input wire logic dqs,
    input wire logic ck_level,
    // Data lines
    output logic [7:0] dq_out,
    output logic [7:0] dq_oe_n,
    output logic dq_undefined,
    // Status
    output logic termination_resistance_on,
    output logic settings_pending,
    output logic dll_locked,
    output logic cmd_error,
    output logic [15:0] base_mode_reg,
    output logic [15:0] aux_mode_reg_a,
    output logic [15:0] aux_mode_reg_b,
    output logic [15:0] aux_mode_reg_c,
    // Burst beat addresses
    output logic [9:0] burst_col,
    output logic burst_valid,
    output logic burst_len8
);
    sdram_init_pkg::top_state_type st_r;
    sdram_init_pkg::top_state_type st_nxt;
    sdram_init_pkg::cmd_type cmd;
    burst_if bif ();

    function automatic sdram_init_pkg::cmd_type decode_cmd(
        input logic c_n, input logic r_n, input logic ca_n, input logic w_n);
        sdram_init_pkg::cmd_type res;
        if (c_n)
        begin
            res = sdram_init_pkg::CMD_DESELECT;
        end
        else
        begin
            case ({r_n, ca_n, w_n})
                3'h7: res = sdram_init_pkg::CMD_NOP;
                3'h0: res = sdram_init_pkg::CMD_MODE_SET;
                3'h5: res = sdram_init_pkg::CMD_READ;
                3'h4: res = sdram_init_pkg::CMD_WRITE;
                default: res = sdram_init_pkg::CMD_OTHER;
            endcase
        end
        return res;
    endfunction : decode_cmd

    function automatic logic is_idle(input sdram_init_pkg::cmd_type c);
        return c == sdram_init_pkg::CMD_NOP || c == sdram_init_pkg::CMD_DESELECT;
    endfunction : is_idle

    burst_addr_gen u_burst (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .bus(bif.gen)
    );

    always_comb
    begin
        logic leveling;
        logic out_en;
        logic rtt_set;
        logic cmd_ok;
        leveling = 1'b0;
        out_en = 1'b0;
        rtt_set = 1'b0;
        cmd_ok = 1'b0;
        st_nxt = st_r;
        cmd = decode_cmd(cs_n, ras_n, cas_n, we_n);
        cmd_ok = cke || st_r.cke_seen;
        bif.load = 1'b0;
        bif.len8 = 1'b1;
        bif.start_col = addr[9:0];
        st_nxt.dqs_prev = dqs;
        st_nxt.cmd_error = 1'b0;

        if (cke)
        begin
            st_nxt.cke_seen = 1'b1;
        end

        // DLL reset bit clears itself once started
        if (st_r.mode_reg[0][`BASE_DLL_RESET_BIT])
        begin
            st_nxt.mode_reg[0][`BASE_DLL_RESET_BIT] = 1'b0;
            st_nxt.dll_cnt = `DLL_LOCK_CYCLES;
            st_nxt.dll_locked = 1'b0;
        end
        else if (st_r.dll_cnt != 10'h000)
        begin
            st_nxt.dll_cnt = st_r.dll_cnt - 10'h001;
            st_nxt.dll_locked = (st_r.dll_cnt == 10'h001);
        end

        if (st_r.mrd_cnt != 5'h00)
        begin
            st_nxt.mrd_cnt = st_r.mrd_cnt - 5'h01;
        end

        case (st_r.mstate)
            sdram_init_pkg::MODE_STABLE:
            begin
                st_nxt.dq_undef = 1'b0;
            end
            sdram_init_pkg::MODE_UPDATING:
            begin
                if (!is_idle(cmd) && cmd != sdram_init_pkg::CMD_MODE_SET)
                begin
                    st_nxt.cmd_error = 1'b1;
                end
                if (st_r.upd_cnt == 5'h01)
                begin
                    st_nxt.active_reg = st_r.mode_reg;
                    st_nxt.mstate = sdram_init_pkg::MODE_STABLE;
                    st_nxt.dq_undef = 1'b0;
                end
                st_nxt.upd_cnt = st_r.upd_cnt - 5'h01;
            end
            default:
            begin
                st_nxt.mstate = sdram_init_pkg::MODE_STABLE;
            end
        endcase

        leveling = st_r.active_reg[1][`AUX_A_LEVEL_BIT];
        out_en = !st_r.active_reg[1][`AUX_A_QOFF_BIT];
        rtt_set = st_r.active_reg[1][`AUX_A_RTT_B0] | st_r.active_reg[1][`AUX_A_RTT_B1]
                  | st_r.active_reg[1][`AUX_A_RTT_B2];

        if (cmd_ok && cmd == sdram_init_pkg::CMD_MODE_SET)
        begin
            if (ba <= `SEL_AUX_C)
            begin
                st_nxt.mode_reg[ba[1:0]] = addr;
                st_nxt.mstate = sdram_init_pkg::MODE_UPDATING;
                st_nxt.upd_cnt = `MODE_UPDATE_CYCLES;
                st_nxt.mrd_cnt = `MODE_TO_MODE_CYCLES;
                if (leveling && ba == `SEL_AUX_A && !addr[`AUX_A_LEVEL_BIT])
                begin
                    st_nxt.dq_undef = 1'b1;
                end
            end
            if (st_r.mrd_cnt != 5'h00 || ba > `SEL_AUX_C)
            begin
                st_nxt.cmd_error = 1'b1;
            end
        end
        else if (cmd_ok && (cmd == sdram_init_pkg::CMD_READ || cmd == sdram_init_pkg::CMD_WRITE))
        begin
            if (leveling)
            begin
                st_nxt.cmd_error = 1'b1;
            end
            bif.load = st_r.mstate == sdram_init_pkg::MODE_STABLE;
            case (st_r.active_reg[0][1:0])
                `BL_FIXED8: bif.len8 = 1'b1;
                `BL_OTF: bif.len8 = addr[`BURST_SEL_BIT];
                `BL_CHOP4: bif.len8 = 1'b0;
                default: bif.len8 = 1'b1;
            endcase
        end
        else if (cmd_ok && cmd == sdram_init_pkg::CMD_OTHER && leveling)
        begin
            st_nxt.cmd_error = 1'b1;
        end

        // Termination held off until clock enable is first seen
        st_nxt.term_on = st_r.cke_seen && termination_enable && rtt_set;

        // Leveling feedback: clock sampled on strobe rise
        if (dqs && !st_r.dqs_prev)
        begin
            st_nxt.ck_sample = ck_level;
        end
        if (leveling && out_en && !st_nxt.dq_undef)
        begin
            st_nxt.dq_oe_n = 8'h00;
            st_nxt.dq_out = {7'h00, st_nxt.ck_sample};
        end
        else
        begin
            st_nxt.dq_oe_n = 8'hff;
            st_nxt.dq_out = 8'h00;
        end

        st_nxt.burst_col = bif.col;
        st_nxt.burst_valid = bif.beat_valid;
        if (bif.load)
        begin
            st_nxt.burst_len8 = bif.len8;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.dq_oe_n <= 8'hff;
            st_r.burst_len8 <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign dq_out = st_r.dq_out;
    assign dq_oe_n = st_r.dq_oe_n;
    assign dq_undefined = st_r.dq_undef;
    assign termination_resistance_on = st_r.term_on;
    assign settings_pending = (st_r.mstate == sdram_init_pkg::MODE_UPDATING);
    assign dll_locked = st_r.dll_locked;
    assign cmd_error = st_r.cmd_error;
    assign base_mode_reg = st_r.mode_reg[0];
    assign aux_mode_reg_a = st_r.mode_reg[1];
    assign aux_mode_reg_b = st_r.mode_reg[2];
    assign aux_mode_reg_c = st_r.mode_reg[3];
    assign burst_col = st_r.burst_col;
    assign burst_valid = st_r.burst_valid;
    assign burst_len8 = st_r.burst_len8;
endmodule : sdram_init_mode_register_control

`default_nettype wire

// file: tb/mem_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdram_init_map.svh"
module mem_ctrl_model #(
    parameter int CKE_WAIT = 4999
) (
    // Clock
    input wire logic clk_sys,
    // Clear and command pins
    output logic rst_n,
    output logic cke,
    output logic cs_n,
    output logic [2:0] rcw,
    output logic [2:0] ba,
    output logic [15:0] addr,
    // Termination and leveling
    output logic termination_enable,
    output logic dqs,
    output logic ck_level
);
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic power_up();
        rst_n = 1'b0;
        cke = 1'b0;
        termination_enable = 1'b0;
        cs_n = 1'b1;
        rcw = 3'h7;
        ba = 3'h0;
        addr = 16'h0000;
        dqs = 1'b0;
        ck_level = 1'b0;
        repeat (3) tick();
        rst_n = 1'b1;
        repeat (CKE_WAIT) tick();
        cke = 1'b1;
        cs_n = 1'b0;
        repeat (5) tick();
    endtask : power_up

    // Released address toggles
    task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [15:0] a);
        rcw = c;
        ba = b;
        addr = a;
        tick();
        rcw = 3'h7;
        addr = ~a;
    endtask : cmd

    task automatic mset(input logic [2:0] b, input logic [15:0] a);
        cmd(3'h0, b, a);
        repeat (`MODE_UPDATE_CYCLES + 1) tick();
    endtask : mset

    task automatic term(input logic v);
        termination_enable = v;
        repeat (2) tick();
    endtask : term

    task automatic strobe(input logic ck);
        ck_level = ck;
        dqs = 1'b1;
        tick();
        dqs = 1'b0;
        ck_level = ~ck;
    endtask : strobe
endmodule : mem_ctrl_model
`default_nettype wire

// file: tb/sdram_init_mode_register_control_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module init_ctrl_checker (
    // Clock and clear pin
    input wire logic clk_sys,
    input wire logic rst_n,
    // Command side
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [15:0] addr,
    input wire logic termination_enable,
    input wire logic dqs,
    input wire logic ck_level,
    // Device outputs
    input wire logic [7:0] dq_out,
    input wire logic [7:0] dq_oe_n,
    input wire logic termination_resistance_on,
    input wire logic settings_pending,
    input wire logic dll_locked,
    input wire logic cmd_error,
    input wire logic [15:0] base_mode_reg,
    input wire logic [15:0] aux_mode_reg_a,
    input wire logic [9:0] burst_col,
    input wire logic burst_valid,
    input wire logic burst_len8
);
    logic ms;
    logic rw;
    assign ms = cke & ~cs_n & ~ras_n & ~cas_n & ~we_n;
    assign rw = cke & ~cs_n & ras_n & ~cas_n;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    property p_pend;
        ms && !ba[2] && !settings_pending |=> settings_pending;
    endproperty
    a_pend: assert property (p_pend)
        else $error("update delay not started");
    property p_hold;
        $fell(settings_pending) |-> $past(settings_pending, 12);
    endproperty
    a_hold: assert property (p_hold)
        else $error("update delay too short");
    property p_keep;
        !ms |=> $stable(aux_mode_reg_a);
    endproperty
    a_keep: assert property (p_keep)
        else $error("register changed without write");
    property p_dll_clr;
        $rose(base_mode_reg[8]) |=> !base_mode_reg[8];
    endproperty
    a_dll_clr: assert property (p_dll_clr)
        else $error("dll reset bit stuck");
    property p_lock;
        $rose(base_mode_reg[8]) |=> !dll_locked ##[505:515] dll_locked;
    endproperty
    a_lock: assert property (p_lock)
        else $error("dll lock timing wrong");
    property p_err;
        ms && ba[2] |=> cmd_error;
    endproperty
    a_err: assert property (p_err)
        else $error("bad select not flagged");
    property p_burst;
        rw && !settings_pending |-> ##2 burst_valid && burst_col == $past(addr[9:0], 2);
    endproperty
    a_burst: assert property (p_burst)
        else $error("burst start wrong");
    property p_wrap8;
        burst_valid && $past(burst_valid) && burst_len8
            |-> burst_col == {$past(burst_col[9:3]), $past(burst_col[2:0]) + 3'h1};
    endproperty
    a_wrap8: assert property (p_wrap8)
        else $error("eight beat wrap wrong");
    property p_level;
        $rose(dqs) && dq_oe_n == 8'h00 |=> dq_out == {7'h00, $past(ck_level)};
    endproperty
    a_level: assert property (p_level)
        else $error("leveling feedback wrong");
    property p_term;
        !termination_enable |=> !termination_resistance_on;
    endproperty
    a_term: assert property (p_term)
        else $error("termination on while disabled");
endmodule : init_ctrl_checker

bind sdram_init_mode_register_control init_ctrl_checker chk_i (.clk_sys, .rst_n, .cke, .cs_n, .ras_n,
    .cas_n, .we_n, .ba, .addr, .termination_enable, .dqs, .ck_level, .dq_out, .dq_oe_n,
    .termination_resistance_on, .settings_pending, .dll_locked, .cmd_error, .base_mode_reg,
    .aux_mode_reg_a, .burst_col, .burst_valid, .burst_len8);
`default_nettype wire

// file: tb/sdram_init_mode_register_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdram_init_map.svh"
module sdram_init_mode_register_control_tb;
    logic clk_sys = 1'b0;
    logic rst_n, cke, cs_n, termination_enable, dqs, ck_level, l8;
    logic dq_undefined, term_on, settings_pending, dll_locked, cmd_error, burst_valid, burst_len8;
    logic [2:0] rcw, ba;
    logic [15:0] addr;
    logic [7:0] dq_out, dq_oe_n;
    logic [15:0] regs [4];
    logic [9:0] burst_col;
    logic [1:0] bl;
    logic [15:0] rnd = 16'h000a;
    logic [2:0] sel [4] = '{3'h2, 3'h3, 3'h1, 3'h0};
    logic [15:0] val [4] = '{16'h0018, 16'h0004, 16'h0044, 16'h0100};
    int failures = 0;
    int cmp_count = 0;
    always #50 clk_sys = ~clk_sys;
    mem_ctrl_model m (.clk_sys, .rst_n, .cke, .cs_n, .rcw, .ba, .addr, .termination_enable, .dqs, .ck_level);
    sdram_init_mode_register_control dut (.clk_sys, .rst_n, .cke, .cs_n, .ras_n(rcw[2]), .cas_n(rcw[1]),
        .we_n(rcw[0]), .ba, .addr, .termination_enable, .dqs, .ck_level, .dq_out, .dq_oe_n, .dq_undefined,
        .termination_resistance_on(term_on), .settings_pending, .dll_locked, .cmd_error,
        .base_mode_reg(regs[0]), .aux_mode_reg_a(regs[1]), .aux_mode_reg_b(regs[2]),
        .aux_mode_reg_c(regs[3]), .burst_col, .burst_valid, .burst_len8);

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic [9:0] beat(input logic [9:0] s, input logic len8, input int i);
        logic [9:0] msk;
        msk = len8 ? 10'h007 : 10'h003;
        return (s & ~msk) | ((s + i[9:0]) & msk);
    endfunction : beat

    task automatic final_report();
        if (failures == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Burst start or end of update delay
    task automatic await(input logic burst);
        int n;
        n = 0;
        while ((burst ? burst_valid : !settings_pending) !== 1'b1 && n < 40)
        begin
            m.tick();
            n++;
        end
        if (n == 40)
        begin
            failures++;
            final_report();
        end
    endtask : await

    initial
    begin
        m.power_up();
        for (int i = 0; i < 4; i++)
        begin
            m.mset(sel[i], val[i]);
            chk(regs[sel[i]], val[i] & 16'hfeff);
        end
        m.cmd(3'h6, 3'h0, 16'h0400);
        repeat (520) m.tick();
        chk(dll_locked, 1'b1);
        m.cmd(3'h0, 3'h5, 16'hffff);
        chk(cmd_error, 1'b1);
        chk(settings_pending, 1'b0);
        chk(regs[1], 16'h0044);
        m.tick();
        m.cmd(3'h0, `SEL_AUX_C, 16'h0000);
        m.tick();
        m.cmd(3'h0, `SEL_AUX_C, 16'h0000);
        chk(cmd_error, 1'b1);
        m.tick();
        m.cmd(3'h5, 3'h0, 16'h0000);
        chk(cmd_error, 1'b1);
        repeat (3) m.tick();
        chk(burst_valid, 1'b0);
        await(1'b0);
        for (int k = 0; k < 12; k++)
        begin
            bl = (k % 3 == 0) ? `BL_FIXED8 : (k % 3 == 1) ? `BL_OTF : `BL_CHOP4;
            m.mset(`SEL_BASE, {14'h0000, bl});
            rnd = lfsr(rnd);
            l8 = bl == `BL_FIXED8 || (bl == `BL_OTF && rnd[12]);
            m.cmd({2'b10, rnd[0]}, 3'h0, rnd);
            await(1'b1);
            for (int i = 0; i < 8; i++)
            begin
                chk(burst_valid ? burst_col : 10'h3ff, (i < 4 || l8) ? beat(rnd[9:0], l8, i) : 10'h3ff);
                m.tick();
            end
            chk(burst_len8, l8);
        end
        m.mset(`SEL_AUX_A, 16'h00c4);
        chk(dq_oe_n, 8'h00);
        m.term(1'b1);
        chk(term_on, 1'b1);
        m.cmd(3'h5, 3'h0, 16'h0000);
        chk(cmd_error, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            m.strobe(rnd[3]);
            chk(dq_out, {7'h00, rnd[3]});
            m.tick();
        end
        m.term(1'b0);
        chk(term_on, 1'b0);
        m.cmd(3'h0, `SEL_AUX_A, 16'h0044);
        chk(dq_undefined, 1'b1);
        await(1'b0);
        m.tick();
        chk(dq_undefined, 1'b0);
        chk(dq_oe_n, 8'hff);
        m.power_up();
        for (int i = 0; i < 4; i++)
            chk(regs[i], 16'h0000);
        chk(dll_locked, 1'b0);
        final_report();
    end
endmodule : sdram_init_mode_register_control_tb
`default_nettype wire
